// File: core/pwm_timing_pkg.sv
// Constants, register map and carrier types of the three-phase timing unit.
// Assumes one 50 MHz clock and a simple strobed register port.
package pwm_timing_pkg;
  // ==========================================================
  // Widths
  localparam int CNT_W = 16;
  localparam int DT_W = 10;
  localparam int MPW_W = 10;
  localparam int SW_W = 8;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // ==========================================================
  // Register indices
  localparam logic [ADDR_W-1:0] OFS_DUTY_A = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_DUTY_B = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_DUTY_C = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_HALF_PERIOD = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_DEAD_TIME = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_MIN_PULSE = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_MODE_CONTROL = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_SYSTEM_STATUS = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_SYNC_WIDTH = 4'h8;
  // ==========================================================
  // Fields and reset values
  localparam int MODE_DOUBLE_BIT = 6;
  localparam int STAT_HALF_BIT = 3;
  localparam int STAT_RUN_BIT = 0;
  localparam logic [SW_W-1:0] SYNC_WIDTH_RST = 8'h27;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [3:0] WRITTEN_ALL = 4'hF;
  // ==========================================================
  // Types
  typedef enum {ST_WAIT, ST_UP, ST_DOWN} count_state_e;
  typedef struct packed {
    logic [CNT_W-1:0] period;
    logic [DT_W-1:0] dead;
    logic [MPW_W-1:0] minpw;
  } timing_s;
endpackage

// File: core/phase_pair.sv
// One complementary active-low output pair of the timing unit.
// Assumes the up/down count and latch strobe from the timing core.
`timescale 1ns/1ps
`default_nettype none
module phase_pair
  import pwm_timing_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic latch,
  input wire logic [CNT_W-1:0] duty,
  input wire timing_s timing,
  input wire logic [CNT_W-1:0] cnt,
  output logic hi_n_ff,
  output logic lo_n_ff
);
  logic [CNT_W:0] on_h_ff, on_l_ff, per_ff;
  logic [CNT_W:0] nxt_on_h, nxt_on_l, per, dead, minpw, dsum, raw_h, raw_l;

  // ==========================================================
  // On-time per half period
  always_comb begin
    per = {1'b0, timing.period};
    dead = (CNT_W+1)'(timing.dead);
    minpw = (CNT_W+1)'(timing.minpw);
    dsum = {1'b0, duty} + dead;
    // Dead time moves both edges away from the duty instant
    raw_h = ({1'b0, duty} > dead) ? {1'b0, duty} - dead : '0; // RULE5 RULE2
    if (raw_h > per) begin
      raw_h = per; // RULE7
    end
    raw_l = (per > dsum) ? per - dsum : '0; // RULE6 RULE7
    nxt_on_h = raw_h;
    nxt_on_l = raw_l;
    // Checked after dead time, not on the raw duty
    if (raw_h < minpw) begin
      nxt_on_h = '0; // RULE16 RULE17
      nxt_on_l = per;
    end else if (raw_l < minpw) begin
      nxt_on_l = '0; // RULE16 RULE17
      nxt_on_h = per;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      on_h_ff <= '0;
      on_l_ff <= '0;
      per_ff <= '0;
    end else if (latch) begin
      on_h_ff <= nxt_on_h; // RULE22 RULE8
      on_l_ff <= nxt_on_l;
      per_ff <= per;
    end
  end

  // ==========================================================
  // Compare against the symmetric count; low level turns a switch on
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hi_n_ff <= 1'b1;
      lo_n_ff <= 1'b1;
    end else if (!run) begin
      hi_n_ff <= 1'b1; // RULE12
      lo_n_ff <= 1'b1;
    end else begin
      hi_n_ff <= !(({1'b0, cnt} + on_h_ff) >= per_ff); // RULE3 RULE23
      lo_n_ff <= !({1'b0, cnt} < on_l_ff); // RULE3
    end
  end
endmodule
`default_nettype wire

// File: core/pwm_timing_unit.sv
// Three-phase center-based PWM timing unit with register port.
// Assumes a synchronous master on a single-cycle strobed register port.
// Functional notes
// RULE1 - Three 16-bit read/write duty registers drive pairs A, B and C.
// RULE2 - Duty count is high-side on-time per half period in clocks.
// RULE3 - All six outputs are active low; low turns a switch on.
// RULE4 - Single update mode uses same values for both halves: symmetric.
// RULE5 - Dead time moves both complementary edges equally off the duty instant.
// RULE6 - High on 2*(duty-dead), low on 2*(period-duty-dead) in single mode.
// RULE7 - On-times clamp between zero and the full period.
// RULE8 - Double mode on-time sums both halves, each with its own values.
// RULE9 - Double mode period is sum of both half period counts.
// RULE10 - Double mode inserts dead time per half exactly as single mode.
// RULE11 - B and C pairs behave exactly like A from their own duties.
// RULE12 - No outputs or counting until period and three duties written once.
// RULE13 - Single mode: one duty step changes on-time 2 clocks per period.
// RULE14 - Double mode: independent halves allow one-clock on-time steps.
// RULE15 - 10-bit read/write minimum on-time register in clocks per half.
// RULE16 - Any on-time below minimum: output off whole half, complement on. When both are short, the code turns only high off and keeps low on.
// RULE17 - Minimum check uses dead-time adjusted on-time, not raw duty.
// RULE18 - Status bit 3 reads zero in first half, one in second.
// RULE19 - Period register holds clock count of half a switching period.
// RULE20 - One shared 10-bit read/write dead-time register for all pairs.
// RULE21 - Mode bit 6 selects double update; cleared after reset.
// RULE22 - Values latch on sync rising edge: period start, and mid in double.
// RULE23 - Up/down counter centres edges about the period midpoint.
`timescale 1ns/1ps
`default_nettype none
module pwm_timing_unit
  import pwm_timing_pkg::*;
#(
  parameter int PHASES = 3
)(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata_ff,
  output logic phase_a_high_out_n,
  output logic phase_a_low_out_n,
  output logic phase_b_high_out_n,
  output logic phase_b_low_out_n,
  output logic phase_c_high_out_n,
  output logic phase_c_low_out_n,
  output logic period_sync_pulse_ff
);
  // ==========================================================
  // Elaboration checks
  if (PHASES != 3) begin : g_bad_phases
    $error("pwm_timing_unit serves exactly three phases");
  end
  if (DT_W > CNT_W || MPW_W > CNT_W) begin : g_bad_widths
    $error("pwm_timing_unit dead or minimum width exceeds count width");
  end

  function automatic logic [CNT_W-1:0] last_count(
    input logic [CNT_W-1:0] period
  );
    // A zero period still gives a one-cycle half
    last_count = (period == CNT_ZERO) ? CNT_ZERO : period - CNT_ONE;
  endfunction

  // ==========================================================
  // Software registers
  logic [PHASES-1:0][CNT_W-1:0] duty_ff;
  logic [CNT_W-1:0] half_period_count_ff;
  logic [DT_W-1:0] dead_time_count_ff;
  logic [MPW_W-1:0] min_pulse_width_ff;
  logic [SW_W-1:0] sync_pulse_width_ff;
  logic mode_double_ff;
  logic [3:0] written_ff;
  timing_s timing_reg;

  assign timing_reg = '{period: half_period_count_ff,
                        dead: dead_time_count_ff,
                        minpw: min_pulse_width_ff};

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      duty_ff <= '0;
      half_period_count_ff <= '0;
      dead_time_count_ff <= '0;
      min_pulse_width_ff <= '0;
      sync_pulse_width_ff <= SYNC_WIDTH_RST;
      mode_double_ff <= 1'b0; // RULE21
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_DUTY_A: duty_ff[0] <= reg_wdata; // RULE1
        OFS_DUTY_B: duty_ff[1] <= reg_wdata; // RULE1
        OFS_DUTY_C: duty_ff[2] <= reg_wdata; // RULE1
        OFS_HALF_PERIOD: half_period_count_ff <= reg_wdata; // RULE19
        OFS_DEAD_TIME: dead_time_count_ff <= reg_wdata[DT_W-1:0]; // RULE20
        OFS_MIN_PULSE: min_pulse_width_ff <= reg_wdata[MPW_W-1:0]; // RULE15
        OFS_MODE_CONTROL: mode_double_ff <= reg_wdata[MODE_DOUBLE_BIT];
        OFS_SYNC_WIDTH: sync_pulse_width_ff <= reg_wdata[SW_W-1:0];
        default: ;
      endcase
    end
  end

  // Sticky write tracking gates the start
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      written_ff <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_DUTY_A: written_ff[0] <= 1'b1; // RULE12
        OFS_DUTY_B: written_ff[1] <= 1'b1; // RULE12
        OFS_DUTY_C: written_ff[2] <= 1'b1; // RULE12
        OFS_HALF_PERIOD: written_ff[3] <= 1'b1; // RULE12
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Up/down half-period counter
  count_state_e state_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] period_l_ff;
  logic latch;
  logic running;
  logic half_end;

  assign running = (state_ff != ST_WAIT);
  assign half_end = (state_ff == ST_UP) ? (cnt_ff >= last_count(period_l_ff))
                                        : (cnt_ff == CNT_ZERO);
  // Start, period start, and midpoint only in double mode
  always_comb begin
    case (state_ff)
      ST_WAIT: latch = (written_ff == WRITTEN_ALL); // RULE12
      ST_UP: latch = half_end && mode_double_ff; // RULE22 RULE4
      ST_DOWN: latch = half_end; // RULE22
      default: latch = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_WAIT;
      cnt_ff <= '0;
    end else begin
      case (state_ff)
        ST_WAIT: begin
          if (latch) begin
            state_ff <= ST_UP; // RULE12
            cnt_ff <= CNT_ZERO;
          end
        end
        ST_UP: begin
          if (cnt_ff >= last_count(period_l_ff)) begin
            state_ff <= ST_DOWN;
            // New half length in double mode gives the summed period
            cnt_ff <= mode_double_ff ? last_count(half_period_count_ff)
                                     : last_count(period_l_ff); // RULE9
          end else begin
            cnt_ff <= cnt_ff + CNT_ONE; // RULE23
          end
        end
        ST_DOWN: begin
          if (cnt_ff == CNT_ZERO) begin
            state_ff <= ST_UP;
          end else begin
            cnt_ff <= cnt_ff - CNT_ONE; // RULE23
          end
        end
        default: begin
          state_ff <= ST_WAIT;
          cnt_ff <= CNT_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      period_l_ff <= '0;
    end else if (latch) begin
      period_l_ff <= half_period_count_ff; // RULE22
    end
  end

  // ==========================================================
  // Sync pulse, width+1 clocks from each latch
  logic [SW_W-1:0] sync_left_ff;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      period_sync_pulse_ff <= 1'b0;
      sync_left_ff <= '0;
    end else if (latch) begin
      period_sync_pulse_ff <= 1'b1; // RULE22
      sync_left_ff <= sync_pulse_width_ff;
    end else if (sync_left_ff != '0) begin
      sync_left_ff <= sync_left_ff - 8'h01;
    end else begin
      period_sync_pulse_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Output pairs; each pair keeps its own half values
  logic [PHASES-1:0] hi_n, lo_n;

  for (genvar p = 0; p < PHASES; p++) begin : g_pair
    phase_pair u_pair (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .run(running),
      .latch(latch),
      .duty(duty_ff[p]), // RULE11 RULE10 RULE13 RULE14
      .timing(timing_reg),
      .cnt(cnt_ff),
      .hi_n_ff(hi_n[p]),
      .lo_n_ff(lo_n[p])
    );
  end

  assign phase_a_high_out_n = hi_n[0];
  assign phase_a_low_out_n = lo_n[0];
  assign phase_b_high_out_n = hi_n[1];
  assign phase_b_low_out_n = lo_n[1];
  assign phase_c_high_out_n = hi_n[2];
  assign phase_c_low_out_n = lo_n[2];

  // ==========================================================
  // Read port, data valid one cycle after the strobe only
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] mode_word;

  always_comb begin
    mode_word = '0;
    mode_word[MODE_DOUBLE_BIT] = mode_double_ff; // RULE21
  end

  always_comb begin
    status_word = '0;
    status_word[STAT_HALF_BIT] = (state_ff == ST_DOWN); // RULE18
    status_word[STAT_RUN_BIT] = running;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_ff <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_DUTY_A: reg_rdata_ff <= duty_ff[0];
        OFS_DUTY_B: reg_rdata_ff <= duty_ff[1];
        OFS_DUTY_C: reg_rdata_ff <= duty_ff[2];
        OFS_HALF_PERIOD: reg_rdata_ff <= half_period_count_ff;
        OFS_DEAD_TIME: reg_rdata_ff <= DATA_W'(dead_time_count_ff);
        OFS_MIN_PULSE: reg_rdata_ff <= DATA_W'(min_pulse_width_ff);
        OFS_MODE_CONTROL: reg_rdata_ff <= mode_word;
        OFS_SYSTEM_STATUS: reg_rdata_ff <= status_word;
        OFS_SYNC_WIDTH: reg_rdata_ff <= DATA_W'(sync_pulse_width_ff);
        default: reg_rdata_ff <= '0;
      endcase
    end else begin
      reg_rdata_ff <= '0;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  // Sync width as latched, and high cycles seen since the last latch
  logic [SW_W-1:0] sync_w_l_ff;
  logic [SW_W:0] sync_high_ff;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync_w_l_ff <= '0;
      sync_high_ff <= '0;
    end else if (latch) begin
      sync_w_l_ff <= sync_pulse_width_ff;
      sync_high_ff <= '0;
    end else if (period_sync_pulse_ff) begin
      sync_high_ff <= sync_high_ff + 1'b1;
    end
  end

  chk_hold_off: assert property ( // RULE12
    !running |=> (hi_n == 3'h7 && lo_n == 3'h7))
    else $error("outputs active before start");
  chk_start_gate: assert property ( // RULE12
    $rose(running) |-> $past(written_ff) == WRITTEN_ALL)
    else $error("started before all writes");
  chk_pair_overlap: assert property ( // RULE5
    running |-> ((hi_n | lo_n) == 3'h7))
    else $error("both switches of a pair on");
  chk_single_mid: assert property ( // RULE4
    (!mode_double_ff && state_ff == ST_UP && half_end) |=>
      $stable(period_l_ff) && !$rose(period_sync_pulse_ff))
    else $error("single mode changed values mid period");
  chk_half_flag: assert property ( // RULE18
    (reg_rd && reg_addr == OFS_SYSTEM_STATUS) |=>
      reg_rdata_ff[STAT_HALF_BIT] == $past(state_ff == ST_DOWN))
    else $error("half flag wrong");
  chk_mode_read: assert property ( // RULE21
    (reg_rd && reg_addr == OFS_MODE_CONTROL) |=>
      reg_rdata_ff[MODE_DOUBLE_BIT] == $past(mode_double_ff))
    else $error("mode bit readback wrong");
  chk_sync_latch: assert property ( // RULE22
    latch |=> period_sync_pulse_ff && period_l_ff == $past(half_period_count_ff))
    else $error("sync or latch missing");
  chk_count_range: assert property ( // RULE23
    running |-> cnt_ff <= last_count(period_l_ff) ||
      (state_ff == ST_DOWN))
    else $error("counter out of range");
  chk_down_turn: assert property ( // RULE9
    (state_ff == ST_DOWN && cnt_ff == CNT_ZERO) |=> state_ff == ST_UP &&
      cnt_ff == CNT_ZERO)
    else $error("period wrap wrong");
  chk_sync_width: assert property ( // RULE22
    period_sync_pulse_ff |-> sync_high_ff <= (SW_W+1)'(sync_w_l_ff))
    else $error("sync pulse too long");
  chk_sync_end: assert property ( // RULE22
    $fell(period_sync_pulse_ff) |->
      sync_high_ff == (SW_W+1)'(sync_w_l_ff) + 1'b1)
    else $error("sync pulse width wrong");
  chk_rdata_idle: assert property ( // RULE1
    !reg_rd |=> reg_rdata_ff == '0)
    else $error("read data outside read slot");
  chk_duty_read: assert property ( // RULE1
    (reg_rd && reg_addr == OFS_DUTY_A) |=>
      reg_rdata_ff == $past(duty_ff[0]))
    else $error("duty readback wrong");
  chk_dead_read: assert property ( // RULE20
    (reg_rd && reg_addr == OFS_DEAD_TIME) |=>
      reg_rdata_ff == DATA_W'($past(dead_time_count_ff)))
    else $error("dead time readback wrong");
  chk_minpw_read: assert property ( // RULE15
    (reg_rd && reg_addr == OFS_MIN_PULSE) |=>
      reg_rdata_ff == DATA_W'($past(min_pulse_width_ff)))
    else $error("minimum pulse readback wrong");
  chk_run_sticky: assert property ( // RULE12
    running |=> running)
    else $error("unit stopped after start");

  cov_start: cover property ($rose(running));
  cov_double_mid: cover property (mode_double_ff && state_ff == ST_UP && latch);
  cov_a_pulse: cover property ($fell(phase_a_high_out_n));
  cov_status_read: cover property (reg_rd && reg_addr == OFS_SYSTEM_STATUS);
  cov_double_start: cover property (mode_double_ff && state_ff == ST_DOWN &&
    latch);
endmodule
`default_nettype wire

// File: test/gate_drive_model.sv
// Inverter gate driver stand-in: counts on-cycles of six active-low gates.
// Assumes gates and sync are sampled on sys_clk; clr restarts the counts.
`timescale 1ns/1ps
`default_nettype none
module gate_drive_model (
  input wire logic sys_clk,
  input wire logic clr,
  input wire logic [5:0] gate_n,
  input wire logic sync,
  output logic [5:0][31:0] on_cnt,
  output logic [31:0] shoot_cnt,
  output logic [31:0] sync_cnt
);
  // ==========================================================
  // Counters
  logic sync_d_ff;
  always_ff @(posedge sys_clk) begin
    sync_d_ff <= sync;
    if (clr) begin
      on_cnt <= '0;
      shoot_cnt <= '0;
      sync_cnt <= '0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        // Low level means the switch is on
        if (!gate_n[i]) on_cnt[i] <= on_cnt[i] + 1;
      end
      // Both switches of one leg on would short the link
      if ((!gate_n[0] && !gate_n[1]) || (!gate_n[2] && !gate_n[3]) ||
          (!gate_n[4] && !gate_n[5])) shoot_cnt <= shoot_cnt + 1;
      if (sync && !sync_d_ff) sync_cnt <= sync_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// File: test/pwm_timing_unit_tb_top.sv
// Self-checking bench of the timing unit against an integer on-time model.
// Assumes the gate driver stand-in and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module pwm_timing_unit_tb_top
  import pwm_timing_pkg::*;
;
  logic sys_clk, nrst, reg_wr, reg_rd, clr, sync;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata_ff, rv;
  logic [5:0] gate_n;
  logic [5:0][31:0] on_cnt;
  logic [31:0] shoot_cnt, sync_cnt, rng;
  int err_count, tests_run;
  int z[3] = '{0, 0, 0};
  pwm_timing_unit #(.PHASES(3)) u_dut (
    .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .phase_a_high_out_n(gate_n[0]),
    .phase_a_low_out_n(gate_n[1]), .phase_b_high_out_n(gate_n[2]),
    .phase_b_low_out_n(gate_n[3]), .phase_c_high_out_n(gate_n[4]),
    .phase_c_low_out_n(gate_n[5]), .period_sync_pulse_ff(sync));
  gate_drive_model u_gate (.sys_clk(sys_clk), .clr(clr), .gate_n(gate_n),
    .sync(sync), .on_cnt(on_cnt), .shoot_cnt(shoot_cnt),
    .sync_cnt(sync_cnt));
  // ==========================================================
  // Bus, model and check helpers
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata_ff;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic void half_on(input int t, d, dt, mn, output int h, l);
    h = d - dt;
    l = t - d - dt;
    if (h < 0) h = 0;
    if (h > t) h = t;
    if (l < 0) l = 0;
    if (l > t) l = t;
    // High side checked first, so when both are short it goes off and low gets the full half
    if (h < mn) begin
      h = 0;
      l = t;
    end else if (l < mn) begin
      l = 0;
      h = t;
    end
  endfunction
  task automatic measure(input int n, input int eh[3], el[3], input int ns);
    @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    repeat (n) @(posedge sys_clk);
    #1;
    for (int p = 0; p < 3; p++) begin
      chk("high on-time", 32'(eh[p]), on_cnt[2*p]);
      chk("low on-time", 32'(el[p]), on_cnt[2*p+1]);
    end
    chk("sync count", 32'(ns), sync_cnt);
    chk("leg overlap", 32'h0, shoot_cnt);
  endtask
  task automatic single(input int t, dt, mn, input int d[3]);
    int eh[3], el[3];
    int h, l;
    wr(OFS_HALF_PERIOD, 16'(t));
    wr(OFS_DEAD_TIME, 16'(dt));
    wr(OFS_MIN_PULSE, 16'(mn));
    for (int p = 0; p < 3; p++) begin
      wr(OFS_DUTY_A + 4'(p), 16'(d[p]));
      half_on(t, d[p], dt, mn, h, l);
      eh[p] = 2 * h;
      el[p] = 2 * l;
    end
    // New values only apply from a period start
    repeat (2) @(posedge sync);
    measure(2 * t, eh, el, 1);
  endtask
  task automatic dbl(input int t1, d1, t2, d2, dt, mn);
    int eh[3], el[3];
    int h1, l1, h2, l2;
    logic [15:0] st;
    logic prev;
    wr(OFS_DEAD_TIME, 16'(dt));
    wr(OFS_MIN_PULSE, 16'(mn));
    for (int p = 0; p < 3; p++) begin
      half_on(t1, d1 + p, dt, mn, h1, l1);
      half_on(t2, d2 + p, dt, mn, h2, l2);
      eh[p] = h1 + h2;
      el[p] = l1 + l2;
    end
    prev = 1'b0;
    fork
      for (int k = 0; k < 10; k++) begin
        // Each latch takes the values written during the half before it
        @(posedge sync);
        rd(OFS_SYSTEM_STATUS, st);
        if (k > 0) chk("half flag", 32'(!prev), 32'(st[STAT_HALF_BIT]));
        prev = st[STAT_HALF_BIT];
        wr(OFS_HALF_PERIOD, 16'(prev ? t1 : t2));
        for (int p = 0; p < 3; p++) wr(OFS_DUTY_A + 4'(p),
                                       16'((prev ? d1 : d2) + p));
      end
      begin
        repeat (5) @(posedge sync);
        measure(t1 + t2, eh, el, 2);
      end
    join
  endtask
  task automatic summarize();
    $display("Checks run %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    summarize();
  end
  initial begin
    logic [3:0] ra[8] = '{4'h4, 4'h5, 4'h6, 4'h8, 4'h0, 4'h3, 4'hF, 4'h7};
    logic [15:0] r0[8] = '{16'h0, 16'h0, 16'h0, 16'h0027, 16'h0, 16'h0,
                           16'h0, 16'h0};
    logic [15:0] r1[8] = '{16'h03FF, 16'h03FF, 16'h0040, 16'h00FF,
                           16'hFFFF, 16'hFFFF, 16'h0, 16'h0};
    int tt[3] = '{40, 60, 30};
    int td[3] = '{0, 3, 2};
    int tm[3] = '{0, 10, 0};
    int dd[3][3] = '{'{2, 20, 39}, '{12, 5, 57}, '{40, 0, 31}};
    int t;
    int d[3];
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, clr} = '0;
    err_count = 0;
    tests_run = 0;
    rng = 32'h4e3628c3;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], rv);
      chk("reset value", 32'(r0[i]), 32'(rv));
      wr(ra[i], 16'hFFFF);
      rd(ra[i], rv);
      chk("written value", 32'(r1[i]), 32'(rv));
    end
    wr(OFS_MODE_CONTROL, 16'h0000);
    wr(OFS_SYNC_WIDTH, 16'h0003);
    wr(OFS_DUTY_A, 16'h000A);
    wr(OFS_DUTY_B, 16'h000A);
    wr(OFS_HALF_PERIOD, 16'h0028);
    measure(100, z, z, 0);
    for (int i = 0; i < 3; i++) single(tt[i], td[i], tm[i], dd[i]);
    for (int i = 0; i < 6; i++) begin
      rng = xs(rng);
      t = 20 + int'(rng[5:0]);
      for (int p = 0; p < 3; p++) d[p] = int'(rng[31:16]) % (t + 6) + p;
      single(t, int'(rng[8:6]), int'(rng[11:9]), d);
    end
    wr(OFS_MODE_CONTROL, 16'h0040);
    dbl(40, 23, 31, 4, 2, 3);
    dbl(30, 15, 30, 16, 0, 0);
    summarize();
  end
endmodule
`default_nettype wire
